// ---- hdl/twpb_pkg.sv ----
// Constants for the trace word packer and its trace memory registers
`default_nettype none
package twpb_pkg;
	// ----------------------------------------
	// Register offsets in the debug segment
	// ----------------------------------------
	localparam logic [15:0] TWPB_OFS_WORD_LO = 16'h3f80; // Trace word, low half, advances read pointer
	localparam logic [15:0] TWPB_OFS_WORD_HI = 16'h3f84; // Trace word, high half
	localparam logic [15:0] TWPB_OFS_RDPTR = 16'h3f88; // Read pointer, byte address
	localparam logic [15:0] TWPB_OFS_WRPTR = 16'h3f90; // Write pointer, byte address plus wrap
	localparam logic [15:0] TWPB_OFS_CTL = 16'h3fc0; // Control and status
	// ----------------------------------------
	// Control and status field positions
	// ----------------------------------------
	localparam int TWPB_CTL_ON = 0; // Master collection
	localparam int TWPB_CTL_EN = 1; // Trace enable
	localparam int TWPB_CTL_IO = 2; // Inhibit overflow
	localparam int TWPB_CTL_OFC = 3; // Off-chip mode
	localparam int TWPB_CTL_OFFCHIP_CLOCK_RATIO = 4; // Off-chip clock ratio
	localparam int TWPB_CTL_SYP = 5; // Sync period field, low bit
	localparam int TWPB_SYP_BITS = 4; // Sync period field width
	localparam int TWPB_CTL_EST = 9; // Special modes enable
	localparam int TWPB_CTL_FCR = 10; // Call and return tracing
	localparam int TWPB_CTL_ER = 11; // Exception tracing
	localparam int TWPB_CTL_BM = 12; // Breakpoint match mode
	localparam int TWPB_CTL_FDT = 13; // Filtered data trace
	localparam int TWPB_CTL_CYC = 14; // Delta cycle mode
	localparam int TWPB_CTL_FDTC = 15; // Extended filtered data trace
	localparam int TWPB_CTL_ILLEGAL = 31; // Illegal combination flag
	localparam int TWPB_WRP_WRAP = 31; // Write pointer wrap flag
	localparam int TWPB_PTR_LSB = 3; // Pointers address 8-byte words
	localparam logic [31:0] TWPB_CTL_RESET = 32'h0000_0000; // Control reset value
	// ----------------------------------------
	// Packing format
	// ----------------------------------------
	localparam int TWPB_MSG_BITS = 58; // Message bits per word
	localparam int TWPB_TAG_BITS = 6; // Tag bits per word
	localparam int TWPB_WORD_BITS = 64; // Whole trace word
	localparam int TWPB_REC_BITS = 57; // Longest record
	localparam logic [5:0] TWPB_MAX_START = 6'd56; // Latest start of first full message
	localparam logic [5:0] TWPB_TAG_AT0 = 6'd58; // Encoded start 0
	localparam logic [5:0] TWPB_TAG_AT16 = 6'd59; // Encoded start 16
	localparam logic [5:0] TWPB_TAG_AT32 = 6'd60; // Encoded start 32
	localparam logic [5:0] TWPB_TAG_AT48 = 6'd61; // Encoded start 48
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam logic [4:0] TWPB_SYNC_EXP_BASE = 5'd8; // Sync period is 2^(field+8)
	localparam int TWPB_DELTA_BITS = 10; // Delta cycle count width
	localparam logic [1:0] TWPB_DIV_HALF = 2'd1; // Divider top for 1:2 trace clock
	localparam logic [1:0] TWPB_DIV_QUARTER = 2'd3; // Divider top for 1:4 trace clock
endpackage : twpb_pkg
`default_nettype wire

// ---- hdl/twpb_top.sv ----
// Trace word packer with circular trace memory and its register port
`default_nettype none
module twpb_top
	import twpb_pkg::*;
#(
	parameter int DEPTH = 64, // Trace memory words, power of two
	parameter bit BOTH_MODES = 1'b1, // Off-chip bit writable
	parameter bit OFC_PRESET = 1'b0 // Off-chip bit value when fixed, forced on each control write; reset gives 0
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic trace_valid, // Record present from core trace output
	input wire logic [56:0] trace_data, // Record bits, zero above length
	input wire logic [5:0] trace_len, // Record length, 1 to 57
	input wire logic trig_on, // Trigger action sets enable
	input wire logic trig_off, // Trigger action clears enable, unless trig_on is also high
	input wire logic reg_req, // Register access strobe
	input wire logic reg_we, // Write when high
	input wire logic [15:0] reg_addr, // Register byte offset
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata, // Read data, one cycle after strobe
	output logic reg_rvalid, // Read data valid pulse
	output logic cpu_stall, // Holds the core off while off-chip memory is full
	output logic sync_request, // Pulse: core emits a sync record
	output logic normal_inhibit, // Normal trace suppressed
	output logic filter_data_en,
	output logic extended_filter_en,
	output logic bp_match_en,
	output logic exception_en,
	output logic call_return_en,
	output logic [9:0] delta_count, // Cycles since last accepted record
	output logic pib_clk_en, // Trace clock rate enable for the unloader
	output logic [63:0] pib_word, // Word handed to the probe unloader
	output logic pib_valid,
	input wire logic pib_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] TOP = AW'(DEPTH - 1);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] ctl; // Writable control bits
		logic illegal; // Mode combination unsupported
		logic [57:0] acc; // Accumulator, zero above fill
		logic [5:0] cnt; // Bits held in accumulator
		logic has_start; // A message began in this word
		logic [5:0] start_pos; // Where it began
		logic [AW-1:0] wr_idx;
		logic wrap;
		logic [AW-1:0] rd_idx;
		logic [AW-1:0] pib_idx; // Unloader read index
		logic [AW:0] fill; // Words waiting for the unloader
		logic [31:0] rdata;
		logic rvalid;
		logic [23:0] sync_cnt;
		logic sync_req;
		logic [9:0] delta;
		logic [1:0] div;
		logic clk_en;
		logic [63:0] pword;
		logic pvalid;
		logic stall;
		logic [6:0] mode; // Inhibit, fdt, ext, bm, er, fcr, cyc
	} twpb_state_s;

	twpb_state_s s_q, s_d;
	logic [63:0] mem [DEPTH]; // Trace memory
	logic word_we; // Memory write this cycle
	logic [63:0] word_data;
	logic accept; // Record taken this cycle
	logic flush; // Collection switched off with bits held
	logic [5:0] tag_start; // Start position put in tag

	// Start position to tag, keeps low nibble nonzero
	function automatic logic [5:0] twpb_tag(input logic [5:0] pos);
		if (pos == 6'd0) begin
			return TWPB_TAG_AT0;
		end else if (pos == 6'd16) begin
			return TWPB_TAG_AT16;
		end else if (pos == 6'd32) begin
			return TWPB_TAG_AT32;
		end else if (pos == 6'd48) begin
			return TWPB_TAG_AT48;
		end else begin
			return pos;
		end
	endfunction : twpb_tag

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [127:0] merged;
		logic [6:0] sum;
		logic [57:0] pad;
		logic [AW:0] fill_n;
		logic [1:0] div_top;
		logic data_filter_trace_enable, bm, er, call_return_trace_enable, special_modes_enable;
		logic [23:0] period;
		merged = '0;
		sum = '0;
		pad = '0;
		fill_n = '0;
		div_top = '0;
		period = '0;
		data_filter_trace_enable = 1'b0;
		bm = 1'b0;
		er = 1'b0;
		call_return_trace_enable = 1'b0;
		special_modes_enable = 1'b0;
		s_d = s_q;
		word_we = 1'b0;
		word_data = '0;
		tag_start = s_q.has_start ? s_q.start_pos : 6'd0;
		s_d.rvalid = 1'b0;
		s_d.sync_req = 1'b0;
		s_d.clk_en = 1'b0;
		// Register access, writes first
		if (reg_req && reg_we) begin
			if (reg_addr == TWPB_OFS_CTL) begin
				s_d.ctl = reg_wdata[15:0];
				if (!BOTH_MODES) begin
					s_d.ctl[TWPB_CTL_OFC] = OFC_PRESET;
				end
			end else if (reg_addr == TWPB_OFS_RDPTR) begin
				s_d.rd_idx = reg_wdata[AW+TWPB_PTR_LSB-1:TWPB_PTR_LSB];
			end else if (reg_addr == TWPB_OFS_WRPTR) begin
				s_d.wr_idx = reg_wdata[AW+TWPB_PTR_LSB-1:TWPB_PTR_LSB];
				s_d.wrap = reg_wdata[TWPB_WRP_WRAP];
			end
		end else if (reg_req) begin
			s_d.rvalid = 1'b1;
			if (reg_addr == TWPB_OFS_WORD_HI) begin
				s_d.rdata = mem[s_q.rd_idx][63:32];
			end else if (reg_addr == TWPB_OFS_WORD_LO) begin
				s_d.rdata = mem[s_q.rd_idx][31:0];
				s_d.rd_idx = (s_q.rd_idx == TOP) ? '0 : s_q.rd_idx + 1'b1;
			end else if (reg_addr == TWPB_OFS_RDPTR) begin
				s_d.rdata = 32'(s_q.rd_idx) << TWPB_PTR_LSB;
			end else if (reg_addr == TWPB_OFS_WRPTR) begin
				s_d.rdata = (32'(s_q.wr_idx) << TWPB_PTR_LSB) | (32'(s_q.wrap) << TWPB_WRP_WRAP);
			end else if (reg_addr == TWPB_OFS_CTL) begin
				s_d.rdata = {s_q.illegal, 15'h0000, s_q.ctl};
			end else begin
				s_d.rdata = 32'h0000_0000; // Unmapped reads zero
			end
		end
		// Trigger actions steer enable after software
		if (trig_on) begin
			s_d.ctl[TWPB_CTL_EN] = 1'b1;
		end else if (trig_off) begin
			s_d.ctl[TWPB_CTL_EN] = 1'b0;
		end
		// Packing: flush beats a new record; stall holds the core
		flush = s_q.ctl[TWPB_CTL_ON] && !s_d.ctl[TWPB_CTL_ON] && (s_q.cnt != 6'd0);
		accept = trace_valid && s_q.ctl[TWPB_CTL_ON] && s_q.ctl[TWPB_CTL_EN] && !s_q.stall && !flush;
		if (flush) begin
			pad = ~((58'h1 << s_q.cnt) - 58'h1);
			word_data = {twpb_tag(tag_start), s_q.acc | pad};
			word_we = 1'b1;
			s_d.acc = '0;
			s_d.cnt = '0;
			s_d.has_start = 1'b0;
		end else if (accept) begin
			merged = {70'h0, s_q.acc} | ({71'h0, trace_data} << s_q.cnt);
			sum = {1'b0, s_q.cnt} + {1'b0, trace_len};
			if (!s_q.has_start) begin
				tag_start = s_q.cnt;
			end
			if (sum >= 7'(TWPB_MSG_BITS)) begin
				word_data = {twpb_tag(tag_start), merged[57:0]};
				word_we = 1'b1;
				s_d.acc = merged[115:58];
				s_d.cnt = 6'(sum - 7'(TWPB_MSG_BITS));
				s_d.has_start = 1'b0;
			end else begin
				s_d.acc = merged[57:0];
				s_d.cnt = sum[5:0];
				s_d.has_start = 1'b1;
				s_d.start_pos = tag_start;
			end
		end
		// Off-chip with a full memory drops, unless stalled beforehand
		if (s_q.ctl[TWPB_CTL_OFC] && s_q.fill == FULL) begin
			word_we = 1'b0;
		end
		fill_n = s_q.fill;
		if (word_we) begin
			s_d.wr_idx = (s_q.wr_idx == TOP) ? '0 : s_q.wr_idx + 1'b1;
			if (s_q.wr_idx == TOP) begin
				s_d.wrap = 1'b1; // Set wins over a pointer write
			end
			if (s_q.ctl[TWPB_CTL_OFC]) begin
				fill_n = fill_n + 1'b1;
			end
		end
		// Trace clock divider, only while off-chip
		div_top = s_q.ctl[TWPB_CTL_OFFCHIP_CLOCK_RATIO] ? TWPB_DIV_HALF : TWPB_DIV_QUARTER;
		if (!s_q.ctl[TWPB_CTL_OFC] || s_q.div >= div_top) begin
			s_d.div = '0;
			s_d.clk_en = s_q.ctl[TWPB_CTL_OFC];
		end else begin
			s_d.div = s_q.div + 2'd1;
		end
		// Unloader drains one word per trace clock enable
		if (s_q.pvalid && pib_ready) begin
			s_d.pvalid = 1'b0;
		end
		if (s_q.ctl[TWPB_CTL_OFC] && s_q.clk_en && s_q.fill != '0 && (!s_q.pvalid || pib_ready)) begin
			s_d.pword = mem[s_q.pib_idx];
			s_d.pvalid = 1'b1;
			s_d.pib_idx = (s_q.pib_idx == TOP) ? '0 : s_q.pib_idx + 1'b1;
			fill_n = fill_n - 1'b1;
		end
		if (!s_q.ctl[TWPB_CTL_OFC]) begin
			fill_n = '0; // On-chip storage overwrites freely
			s_d.pib_idx = s_d.wr_idx;
		end
		s_d.fill = fill_n;
		// One slot of slack so the word in flight still lands
		s_d.stall = s_d.ctl[TWPB_CTL_OFC] && s_d.ctl[TWPB_CTL_IO] && (fill_n >= FULL - 1'b1);
		// Sync period counts accepted records
		period = 24'h1 << (5'(s_q.ctl[TWPB_CTL_SYP+:TWPB_SYP_BITS]) + TWPB_SYNC_EXP_BASE);
		if (accept) begin
			if (s_q.sync_cnt >= period - 24'h1) begin
				s_d.sync_cnt = '0;
				s_d.sync_req = 1'b1;
			end else begin
				s_d.sync_cnt = s_q.sync_cnt + 24'h1;
			end
		end
		// Delta cycle count, restarts on each record
		if (!s_q.ctl[TWPB_CTL_CYC] || accept) begin
			s_d.delta = '0;
		end else if (s_q.delta != '1) begin
			s_d.delta = s_q.delta + 10'h001;
		end
		// Mode outputs and illegal combination
		data_filter_trace_enable = s_d.ctl[TWPB_CTL_FDT];
		bm = s_d.ctl[TWPB_CTL_BM];
		er = s_d.ctl[TWPB_CTL_ER];
		call_return_trace_enable = s_d.ctl[TWPB_CTL_FCR];
		special_modes_enable = s_d.ctl[TWPB_CTL_EST];
		s_d.mode[6] = special_modes_enable || data_filter_trace_enable || bm || er;
		s_d.mode[5] = data_filter_trace_enable;
		s_d.mode[4] = data_filter_trace_enable && s_d.ctl[TWPB_CTL_FDTC];
		s_d.mode[3] = bm;
		s_d.mode[2] = er;
		s_d.mode[1] = call_return_trace_enable;
		s_d.mode[0] = s_d.ctl[TWPB_CTL_CYC];
		// Fdt and bm exclude the other special modes, er and fcr may combine; all need the special enable
		s_d.illegal = (data_filter_trace_enable && (bm || er || call_return_trace_enable)) || (bm && (er || call_return_trace_enable))
			|| (!special_modes_enable && (data_filter_trace_enable || bm || er || call_return_trace_enable));
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Trace memory has no reset: contents are undefined until written
	always_ff @(posedge clk) begin
		if (word_we) begin
			mem[s_q.wr_idx] <= word_data;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata = s_q.rdata;
	assign reg_rvalid = s_q.rvalid;
	assign cpu_stall = s_q.stall;
	assign sync_request = s_q.sync_req;
	assign normal_inhibit = s_q.mode[6];
	assign filter_data_en = s_q.mode[5];
	assign extended_filter_en = s_q.mode[4];
	assign bp_match_en = s_q.mode[3];
	assign exception_en = s_q.mode[2];
	assign call_return_en = s_q.mode[1];
	assign delta_count = s_q.delta;
	assign pib_clk_en = s_q.clk_en;
	assign pib_word = s_q.pword;
	assign pib_valid = s_q.pvalid;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_tag_nibble: assert property (@(posedge clk) disable iff (!rstn) word_we |-> word_data[61:58] != 4'h0)
		else $error("tag low nibble is zero");
	a_start_range: assert property (@(posedge clk) disable iff (!rstn)
		s_q.has_start |-> s_q.start_pos <= TWPB_MAX_START)
		else $error("start position beyond 56");
	a_tag_zero: assert property (@(posedge clk) disable iff (!rstn)
		(word_we && tag_start == 6'd0) |-> word_data[63:58] == TWPB_TAG_AT0)
		else $error("start zero not encoded as 58");
	a_flush_pad: assert property (@(posedge clk) disable iff (!rstn)
		flush |-> word_we || s_q.fill == FULL ##1 s_q.cnt == 6'd0 && !s_q.has_start)
		else $error("flush left bits in accumulator");
	a_pad_ones: assert property (@(posedge clk) disable iff (!rstn) flush |-> word_data[57] == 1'b1)
		else $error("flush padding not ones");
	a_rd_advance: assert property (@(posedge clk) disable iff (!rstn)
		(reg_req && !reg_we && reg_addr == TWPB_OFS_WORD_LO) |=>
		s_q.rd_idx == (($past(s_q.rd_idx) == TOP) ? '0 : $past(s_q.rd_idx) + 1'b1) && s_q.rvalid)
		else $error("read pointer did not advance");
	a_rd_hold: assert property (@(posedge clk) disable iff (!rstn)
		(reg_req && !reg_we && reg_addr == TWPB_OFS_WORD_HI) |=> $stable(s_q.rd_idx))
		else $error("upper read moved pointer");
	a_wrap_set: assert property (@(posedge clk) disable iff (!rstn)
		(word_we && s_q.wr_idx == TOP) |=> s_q.wrap && s_q.wr_idx == '0)
		else $error("wrap flag not set at top");
	a_stall_full: assert property (@(posedge clk) disable iff (!rstn)
		(s_q.ctl[TWPB_CTL_OFC] && s_q.ctl[TWPB_CTL_IO] && s_q.fill == FULL) |-> s_q.stall)
		else $error("no stall with full memory");
	a_illegal_flag: assert property (@(posedge clk) disable iff (!rstn)
		(s_q.ctl[TWPB_CTL_FDT] && s_q.ctl[TWPB_CTL_BM]) |-> s_q.illegal)
		else $error("illegal combination not flagged");
	a_clk_ratio: assert property (@(posedge clk) disable iff (!rstn)
		(s_q.clk_en && s_q.ctl[TWPB_CTL_OFC] && s_q.ctl[TWPB_CTL_OFFCHIP_CLOCK_RATIO] && $stable(s_q.ctl)) |=> !s_q.clk_en)
		else $error("trace clock enable too frequent");
endmodule : twpb_top
`default_nettype wire

// ---- verification/twpb_core_model.sv ----
// Core trace output model feeding records into the packer
`default_nettype none
module twpb_core_model (
	input wire logic clk,
	input wire logic cpu_stall,
	output logic trace_valid,
	output logic [56:0] trace_data,
	output logic [5:0] trace_len
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Record queue, {length, bits}
	// ----------------------------------------
	logic [62:0] q[$];
	// Queue one record; bits above its length are cleared
	task automatic push(input logic [5:0] len, input logic [56:0] bits);
		q.push_back({len, bits & ((57'h1 << len) - 57'h1)});
	endtask : push
	// True while records wait to be taken
	function automatic bit pending();
		return q.size() != 0;
	endfunction : pending
	// Quiet lines at time zero
	initial begin
		trace_valid = 1'b0;
		trace_data = 57'h0;
		trace_len = 6'h0;
	end
	// A record counts as taken only at an edge without stall
	always @(posedge clk) begin
		if (trace_valid && !cpu_stall) begin
			void'(q.pop_front());
		end
	end
	// Present the head record; idle lines toggle so stale data never looks valid
	always @(negedge clk) begin
		trace_valid <= q.size() != 0;
		trace_len <= q.size() != 0 ? q[0][62:57] : ~trace_len;
		trace_data <= q.size() != 0 ? q[0][56:0] : ~trace_data;
	end
endmodule : twpb_core_model
`default_nettype wire

// ---- verification/twpb_top_bench.sv ----
// Self-checking bench for the trace word packer
`default_nettype none
module twpb_top_bench
	import twpb_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Stimulus, observed outputs, counters
	// ----------------------------------------
	localparam logic [39:0] KA = 40'hab_cdef_1234;
	localparam logic [33:0] KB = 34'h2_5a5a_c3c3;
	localparam logic [19:0] KC = 20'h9_f00d;
	localparam logic [29:0] KD = 30'h2bad_cafe;
	localparam logic [56:0] KP = 57'h0ab_cdef_0123_4567;
	logic clk = 1'b0, rstn = 1'b0, trig_on = 1'b0, trig_off = 1'b0;
	logic reg_req = 1'b0, reg_we = 1'b0, pib_ready = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [31:0] reg_rdata;
	logic reg_rvalid, cpu_stall, sync_request, normal_inhibit, filter_data_en, extended_filter_en;
	logic bp_match_en, exception_en, call_return_en, pib_clk_en, pib_valid, trace_valid;
	logic [9:0] delta_count;
	logic [63:0] pib_word;
	logic [56:0] trace_data;
	logic [5:0] trace_len;
	int bad_count = 0, n_compared = 0, sync_seen = 0, ce_seen = 0;
	// Small memory keeps wrap cases short
	twpb_top #(.DEPTH(8)) i_twpb_top (.clk, .rstn, .trace_valid, .trace_data, .trace_len, .trig_on, .trig_off,
		.reg_req, .reg_we, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .cpu_stall, .sync_request,
		.normal_inhibit, .filter_data_en, .extended_filter_en, .bp_match_en, .exception_en, .call_return_en,
		.delta_count, .pib_clk_en, .pib_word, .pib_valid, .pib_ready);
	twpb_core_model i_twpb_core_model (.clk, .cpu_stall, .trace_valid, .trace_data, .trace_len);
	// Clock and pulse counters
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		sync_seen <= sync_seen + int'(sync_request);
		ce_seen <= ce_seen + int'(pib_clk_en);
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic print_verdict();
		$display("compared %0d, wrong %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict
	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check
	// One strobe cycle; read data comes back one cycle later
	task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
		@(negedge clk);
		reg_req = 1'b1;
		reg_we = 1'b0;
		reg_addr = a;
		@(negedge clk);
		reg_req = 1'b0;
		d = reg_rdata;
		check(64'(reg_rvalid), 64'h1);
	endtask : reg_rd
	task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge clk);
		reg_req = 1'b1;
		reg_we = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_req = 1'b0;
	endtask : reg_wr
	// Upper half first, since the lower read moves the pointer
	task automatic rd_word(output logic [63:0] w);
		reg_rd(TWPB_OFS_WORD_HI, w[63:32]);
		reg_rd(TWPB_OFS_WORD_LO, w[31:0]);
	endtask : rd_word
	task automatic wait_idle();
		for (int i = 0; i < 600 && i_twpb_core_model.pending(); i++) @(negedge clk);
		repeat (3) @(negedge clk);
	endtask : wait_idle
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask : pulse
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [15:0] a [4] = '{TWPB_OFS_CTL, TWPB_OFS_RDPTR, TWPB_OFS_WRPTR, 16'h3f00};
		logic [31:0] d;
		foreach (a[i]) begin
			reg_rd(a[i], d);
			check(64'(d), 64'h0);
		end
	endtask : t_reset
	// Straddling records, start-16 tag, flush with ones
	task automatic t_pack();
		logic [63:0] w;
		logic [31:0] d;
		reg_wr(TWPB_OFS_WRPTR, 32'h0);
		reg_wr(TWPB_OFS_CTL, 32'h3);
		i_twpb_core_model.push(6'd40, 57'(KA));
		i_twpb_core_model.push(6'd34, 57'(KB));
		i_twpb_core_model.push(6'd20, 57'(KC));
		i_twpb_core_model.push(6'd30, 57'(KD));
		wait_idle();
		reg_wr(TWPB_OFS_CTL, 32'h0);
		reg_rd(TWPB_OFS_WRPTR, d);
		check(64'(d), 64'h18);
		reg_wr(TWPB_OFS_RDPTR, 32'h0);
		rd_word(w);
		check(w, {6'd58, KB[17:0], KA});
		check(64'(|w[61:58]), 64'h1);
		rd_word(w);
		check(w, {6'd59, KD[21:0], KC, KB[33:18]});
		rd_word(w);
		check(w, {6'd58, {50{1'b1}}, KD[29:22]});
		reg_rd(TWPB_OFS_RDPTR, d);
		check(64'(d), 64'h18);
	endtask : t_pack
	// Both pointers wrap at the top of memory
	task automatic t_wrap();
		logic [63:0] w;
		logic [31:0] d;
		reg_wr(TWPB_OFS_WRPTR, 32'h38);
		reg_wr(TWPB_OFS_CTL, 32'h3);
		i_twpb_core_model.push(6'd40, 57'(KA));
		i_twpb_core_model.push(6'd30, 57'(KD));
		i_twpb_core_model.push(6'd5, 57'h15);
		wait_idle();
		reg_wr(TWPB_OFS_CTL, 32'h0);
		reg_rd(TWPB_OFS_WRPTR, d);
		check(64'(d), 64'h8000_0008);
		reg_wr(TWPB_OFS_RDPTR, 32'h38);
		rd_word(w);
		check(w, {6'd58, KD[17:0], KA});
		reg_rd(TWPB_OFS_RDPTR, d);
		check(64'(d), 64'h0);
		rd_word(w);
		check(w, {6'd12, {41{1'b1}}, 5'h15, KD[29:18]});
		reg_wr(TWPB_OFS_WRPTR, 32'h0);
		reg_rd(TWPB_OFS_WRPTR, d);
		check(64'(d), 64'h0);
	endtask : t_wrap
	// Mode combinations, illegal flag and mode levels
	task automatic t_modes();
		logic [31:0] v [7] = '{32'h2200, 32'h0e00, 32'h1a00, 32'h2000, 32'h1200, 32'he200, 32'hffff_ffff};
		logic [31:0] d;
		logic ill;
		foreach (v[i]) begin
			ill = (v[i][13] & (|v[i][12:10])) | (v[i][12] & (|v[i][11:10])) | ((|v[i][13:10]) & ~v[i][9]);
			reg_wr(TWPB_OFS_CTL, v[i]);
			reg_rd(TWPB_OFS_CTL, d);
			check(64'(d), 64'({ill, 15'h0, v[i][15:0]}));
			check(64'({normal_inhibit, filter_data_en, extended_filter_en, bp_match_en, exception_en,
				call_return_en}), 64'({(|v[i][13:11]) | v[i][9], v[i][13], v[i][15] & v[i][13],
				v[i][12:10]}));
		end
		reg_wr(TWPB_OFS_CTL, 32'h0);
		// Delta mode alone: count climbs one per cycle, then clears when mode drops
		reg_wr(TWPB_OFS_CTL, 32'h4000);
		repeat (10) @(negedge clk);
		check(64'(delta_count), 64'd10);
		reg_wr(TWPB_OFS_CTL, 32'h0);
		@(negedge clk);
		check(64'(delta_count), 64'd0);
	endtask : t_modes
	// Field zero gives one sync every 256 records
	task automatic t_sync();
		int s0;
		reg_wr(TWPB_OFS_CTL, 32'h3);
		s0 = sync_seen;
		repeat (512) i_twpb_core_model.push(6'd1, 57'h1);
		wait_idle();
		check(64'(sync_seen - s0), 64'd2);
		reg_wr(TWPB_OFS_CTL, 32'h0);
	endtask : t_sync
	// Trigger toggles keep the partial word; clearing collection flushes it
	task automatic t_trig();
		logic [31:0] d, w1;
		reg_wr(TWPB_OFS_CTL, 32'h1);
		pulse(trig_on);
		reg_rd(TWPB_OFS_CTL, d);
		check(64'(d), 64'h3);
		i_twpb_core_model.push(6'd20, 57'(KC));
		wait_idle();
		reg_rd(TWPB_OFS_WRPTR, w1);
		pulse(trig_off);
		reg_rd(TWPB_OFS_CTL, d);
		check(64'(d), 64'h1);
		pulse(trig_on);
		reg_rd(TWPB_OFS_WRPTR, d);
		check(64'(d), 64'(w1));
		reg_wr(TWPB_OFS_CTL, 32'h0);
		reg_rd(TWPB_OFS_WRPTR, d);
		check(64'(d[5:0]), 64'(6'(w1[5:0] + 6'h8)));
	endtask : t_trig
	// Trace clock ratios, then a stalled unloader filling memory
	task automatic t_offchip();
		int c0;
		reg_wr(TWPB_OFS_CTL, 32'h1b);
		// Divider starts from idle, so skip its first two edges before counting
		repeat (2) @(negedge clk);
		c0 = ce_seen;
		repeat (16) @(negedge clk);
		check(64'(ce_seen - c0), 64'd8);
		reg_wr(TWPB_OFS_CTL, 32'h0b);
		c0 = ce_seen;
		repeat (16) @(negedge clk);
		check(64'(ce_seen - c0), 64'd4);
		reg_wr(TWPB_OFS_CTL, 32'h1f);
		repeat (10) i_twpb_core_model.push(6'd57, KP);
		repeat (60) @(negedge clk);
		check(64'({cpu_stall, pib_valid}), 64'h3);
		check(pib_word, {6'd58, KP[0], KP});
		pib_ready = 1'b1;
		wait_idle();
		repeat (40) @(negedge clk);
		check(64'(cpu_stall), 64'h0);
		reg_wr(TWPB_OFS_CTL, 32'h0);
	endtask : t_offchip
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		t_reset();
		t_pack();
		t_wrap();
		t_modes();
		t_sync();
		t_trig();
		t_offchip();
		print_verdict();
	end
	// Whole run needs about a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		print_verdict();
	end
endmodule : twpb_top_bench
`default_nettype wire
